// [mccs_pkg.sv]
package mccs_pkg;
  // ----------------------------------------
  // register addresses and layout
  // ----------------------------------------
  localparam logic [7:0] CLOCK_RATE_CONTROL_ADDR = 8'h8f;
  localparam logic [7:0] SERIAL_PERIPH_CLOCK_CONTROL_ADDR = 8'h9f;
  localparam logic [7:0] CLOCK_RATE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SERIAL_PERIPH_CLOCK_CONTROL_RESET = 8'h00;
  localparam int CPU_DOUBLE_SPEED_BIT = 0;
  localparam int TIMER_ZERO_RATE_SEL_BIT = 1;
  localparam int TIMER_ONE_RATE_SEL_BIT = 2;
  localparam int TIMER_TWO_RATE_SEL_BIT = 3;
  localparam int SERIAL_PORT_RATE_SEL_BIT = 4;
  localparam int COUNTER_ARRAY_RATE_SEL_BIT = 5;
  localparam int WATCHDOG_RATE_SEL_BIT = 6;
  localparam int CAN_RATE_SEL_BIT = 7;
  localparam int SPI_RATE_SEL_BIT = 0;
  localparam logic [7:0] SERIAL_PERIPH_WRITABLE = 8'h01;
  // ----------------------------------------
  // period counts
  // ----------------------------------------
  localparam logic [3:0] PERIODS_STANDARD = 4'hc;
  localparam logic [3:0] PERIODS_DOUBLE = 4'h6;
  localparam int NUM_PERIPH = 8;
endpackage

// [mccs_rate_sel.sv]
`timescale 1ns/100ps
`default_nettype none
// one peripheral's effective rate
module mccs_rate_sel (
  input wire logic cpu_double_speed,
  input wire logic rate_sel,
  output logic double_en,
  output logic [3:0] periods
);
  assign double_en = cpu_double_speed & ~rate_sel;
  assign periods = double_en ? mccs_pkg::PERIODS_DOUBLE : mccs_pkg::PERIODS_STANDARD;
endmodule
`default_nettype wire

// [mccs_clock_select.sv]
`timescale 1ns/100ps
`default_nettype none
// peripheral order: 0 timer0, 1 timer1, 2 timer2, 3 serial, 4 counter array,
// 5 watchdog, 6 can, 7 spi
module mccs_clock_select (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  output logic [7:0] SFR_RDATA,
  output logic SFR_RSEL,
  output logic CORE_CLK_EN,
  output logic CPU_DOUBLE_SPEED,
  output logic [3:0] MACHINE_PERIODS,
  output logic [7:0] PERIPH_DOUBLE_EN,
  output logic [31:0] PERIPH_PERIODS
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] clock_rate_control;
    logic [7:0] serial_periph_clock_control;
    logic div_phase;
    logic cpu_double_speed;
    logic [7:0] rdata;
    logic rsel;
  } mccs_state_s;

  mccs_state_s cur;
  mccs_state_s next_cur;
  logic [7:0] sel_bits;

  always_comb begin
    next_cur = cur;
    next_cur.rsel = 1'b0;
    if (SFR_WR && SFR_ADDR == mccs_pkg::CLOCK_RATE_CONTROL_ADDR) begin
      next_cur.clock_rate_control = SFR_WDATA;
    end
    if (SFR_WR && SFR_ADDR == mccs_pkg::SERIAL_PERIPH_CLOCK_CONTROL_ADDR) begin
      // reserved bits are kept at zero so a stray write cannot upset them
      next_cur.serial_periph_clock_control = SFR_WDATA & mccs_pkg::SERIAL_PERIPH_WRITABLE;
    end
    if (SFR_RD && SFR_ADDR == mccs_pkg::CLOCK_RATE_CONTROL_ADDR) begin
      next_cur.rdata = cur.clock_rate_control;
      next_cur.rsel = 1'b1;
    end
    if (SFR_RD && SFR_ADDR == mccs_pkg::SERIAL_PERIPH_CLOCK_CONTROL_ADDR) begin
      next_cur.rdata = cur.serial_periph_clock_control;
      next_cur.rsel = 1'b1;
    end
    // divide-by-two phase of the oscillator
    next_cur.div_phase = ~cur.div_phase;
    // apart from reset, mode only changes at the divided clock rising edge to avoid glitches
    if (!cur.div_phase) begin
      next_cur.cpu_double_speed = cur.clock_rate_control[mccs_pkg::CPU_DOUBLE_SPEED_BIT];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cur.clock_rate_control <= mccs_pkg::CLOCK_RATE_CONTROL_RESET;
      cur.serial_periph_clock_control <= mccs_pkg::SERIAL_PERIPH_CLOCK_CONTROL_RESET;
      cur.div_phase <= 1'b0;
      cur.cpu_double_speed <= 1'b0;
      cur.rdata <= 8'h00;
      cur.rsel <= 1'b0;
    end else if (CE) begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign SFR_RDATA = cur.rdata;
  assign SFR_RSEL = cur.rsel;
  assign CPU_DOUBLE_SPEED = cur.cpu_double_speed;
  // bypass the divider in double speed, otherwise every second oscillator cycle
  assign CORE_CLK_EN = CE & (cur.cpu_double_speed | cur.div_phase);
  assign MACHINE_PERIODS = cur.cpu_double_speed ? mccs_pkg::PERIODS_DOUBLE
                                                : mccs_pkg::PERIODS_STANDARD;

  assign sel_bits = {cur.serial_periph_clock_control[mccs_pkg::SPI_RATE_SEL_BIT],
                     cur.clock_rate_control[7:1]};

  genvar g;
  generate
    for (g = 0; g < mccs_pkg::NUM_PERIPH; g++) begin : g_periph
      mccs_rate_sel u_sel (
        .cpu_double_speed(cur.cpu_double_speed),
        .rate_sel(sel_bits[g]),
        .double_en(PERIPH_DOUBLE_EN[g]),
        .periods(PERIPH_PERIODS[4*g +: 4])
      );
    end
  endgenerate

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_periph_rate;
    @(posedge SYS_CLK) disable iff (RST)
    PERIPH_DOUBLE_EN[0] == (cur.cpu_double_speed && !cur.clock_rate_control[1]);
  endproperty
  a_periph_rate: assert property (p_periph_rate) else $error("timer0 rate wrong");

  property p_ignore_when_std;
    @(posedge SYS_CLK) disable iff (RST)
    !CPU_DOUBLE_SPEED |-> PERIPH_DOUBLE_EN == 8'h00;
  endproperty
  a_ignore_when_std: assert property (p_ignore_when_std) else $error("periph fast in std");

  property p_periods;
    @(posedge SYS_CLK) disable iff (RST)
    PERIPH_PERIODS[27:24] == (sel_bits[6] || !CPU_DOUBLE_SPEED ? 4'hc : 4'h6);
  endproperty
  a_periods: assert property (p_periods) else $error("can periods wrong");

  property p_reserved_zero;
    @(posedge SYS_CLK) disable iff (RST)
    cur.serial_periph_clock_control[7:1] == 7'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_reset_clear;
    @(posedge SYS_CLK) RST |=> (cur.clock_rate_control == 8'h00 && !CPU_DOUBLE_SPEED);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset not clear");

  property p_machine;
    @(posedge SYS_CLK) disable iff (RST)
    MACHINE_PERIODS == (CPU_DOUBLE_SPEED ? 4'h6 : 4'hc);
  endproperty
  a_machine: assert property (p_machine) else $error("machine periods wrong");

  sequence s_std_phase;
    CE && !CPU_DOUBLE_SPEED && !cur.div_phase;
  endsequence
  property p_divide;
    @(posedge SYS_CLK) disable iff (RST)
    s_std_phase |-> !CORE_CLK_EN;
  endproperty
  a_divide: assert property (p_divide) else $error("core clock not divided");

  // a reset also drops the mode, off the divided edge, so that edge is left out
  property p_switch_edge;
    @(posedge SYS_CLK) disable iff (RST)
    (CE && $past(CE) && !$past(RST) && CPU_DOUBLE_SPEED != $past(CPU_DOUBLE_SPEED))
      |-> cur.div_phase;
  endproperty
  a_switch_edge: assert property (p_switch_edge) else $error("mode switched off edge");

  // ----------------------------------------
  // register access checks
  // ----------------------------------------
  sequence s_write_rate;
    CE && !RST && SFR_WR && SFR_ADDR == mccs_pkg::CLOCK_RATE_CONTROL_ADDR;
  endsequence
  sequence s_write_serial;
    CE && !RST && SFR_WR && SFR_ADDR == mccs_pkg::SERIAL_PERIPH_CLOCK_CONTROL_ADDR;
  endsequence
  sequence s_read_rate;
    CE && !RST && SFR_RD && SFR_ADDR == mccs_pkg::CLOCK_RATE_CONTROL_ADDR;
  endsequence
  sequence s_read_serial;
    CE && !RST && SFR_RD && SFR_ADDR == mccs_pkg::SERIAL_PERIPH_CLOCK_CONTROL_ADDR;
  endsequence

  property p_write_rate;
    @(posedge SYS_CLK) disable iff (RST)
    s_write_rate |=> cur.clock_rate_control == $past(SFR_WDATA);
  endproperty
  a_write_rate: assert property (p_write_rate) else $error("rate register write lost");

  property p_write_serial;
    @(posedge SYS_CLK) disable iff (RST)
    s_write_serial |=> cur.serial_periph_clock_control[mccs_pkg::SPI_RATE_SEL_BIT] ==
      $past(SFR_WDATA[mccs_pkg::SPI_RATE_SEL_BIT]);
  endproperty
  a_write_serial: assert property (p_write_serial) else $error("spi select write lost");

  // a read and a write in one cycle return the old value
  property p_read_rate;
    @(posedge SYS_CLK) disable iff (RST)
    s_read_rate |=> SFR_RSEL && SFR_RDATA == $past(cur.clock_rate_control);
  endproperty
  a_read_rate: assert property (p_read_rate) else $error("rate register read wrong");

  property p_read_serial;
    @(posedge SYS_CLK) disable iff (RST)
    s_read_serial |=> SFR_RSEL && SFR_RDATA == $past(cur.serial_periph_clock_control);
  endproperty
  a_read_serial: assert property (p_read_serial) else $error("serial register read wrong");

  // ----------------------------------------
  // mode and divider checks
  // ----------------------------------------
  sequence s_load_edge;
    CE && !RST && !cur.div_phase;
  endsequence
  sequence s_hold_edge;
    CE && !RST && cur.div_phase;
  endsequence
  sequence s_frozen;
    !CE && !RST;
  endsequence

  property p_load_edge;
    @(posedge SYS_CLK) disable iff (RST)
    s_load_edge |=> CPU_DOUBLE_SPEED ==
      $past(cur.clock_rate_control[mccs_pkg::CPU_DOUBLE_SPEED_BIT]);
  endproperty
  a_load_edge: assert property (p_load_edge) else $error("mode not loaded on edge");

  property p_hold_edge;
    @(posedge SYS_CLK) disable iff (RST)
    s_hold_edge |=> $stable(CPU_DOUBLE_SPEED);
  endproperty
  a_hold_edge: assert property (p_hold_edge) else $error("mode moved between edges");

  property p_phase_rise;
    @(posedge SYS_CLK) disable iff (RST)
    s_load_edge |=> cur.div_phase;
  endproperty
  a_phase_rise: assert property (p_phase_rise) else $error("divider did not rise");

  property p_phase_fall;
    @(posedge SYS_CLK) disable iff (RST)
    s_hold_edge |=> !cur.div_phase;
  endproperty
  a_phase_fall: assert property (p_phase_fall) else $error("divider did not fall");

  property p_double_tick;
    @(posedge SYS_CLK) disable iff (RST)
    CE && CPU_DOUBLE_SPEED |-> CORE_CLK_EN;
  endproperty
  a_double_tick: assert property (p_double_tick) else $error("double speed tick missing");

  // a frozen block must hold the divider phase, or the core would lose a tick
  property p_freeze;
    @(posedge SYS_CLK) disable iff (RST)
    s_frozen |=> $stable(cur);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  property p_frozen_tick;
    @(posedge SYS_CLK) disable iff (RST)
    s_frozen |-> !CORE_CLK_EN;
  endproperty
  a_frozen_tick: assert property (p_frozen_tick) else $error("core tick while frozen");
endmodule
`default_nettype wire

// [mccs_clock_select_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module mccs_clock_select_tb_top;
  logic SYS_CLK = 1'b0, RST = 1'b1, CE = 1'b1, SFR_WR = 1'b0, SFR_RD = 1'b0;
  logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA;
  logic SFR_RSEL, CORE_CLK_EN, CPU_DOUBLE_SPEED;
  logic [1:0] ce2;
  logic [3:0] MACHINE_PERIODS;
  logic [7:0] PERIPH_DOUBLE_EN;
  logic [31:0] PERIPH_PERIODS, per;
  // row: first register, second register (reserved bits kept clear), expected double enables
  logic [23:0] rows [7] = '{24'h000000, 24'hff0100, 24'h0100ff, 24'hfe0100, 24'h550155,
    24'haa0000, 24'hab00aa};
  int n_fail = 0, checks = 0, k0;
  always #4 SYS_CLK = ~SYS_CLK;
  mccs_clock_select i_mccs_clock_select (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE),
    .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
    .SFR_RDATA(SFR_RDATA), .SFR_RSEL(SFR_RSEL), .CORE_CLK_EN(CORE_CLK_EN),
    .CPU_DOUBLE_SPEED(CPU_DOUBLE_SPEED), .MACHINE_PERIODS(MACHINE_PERIODS),
    .PERIPH_DOUBLE_EN(PERIPH_DOUBLE_EN), .PERIPH_PERIODS(PERIPH_PERIODS));
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // one strobe cycle; returns just after the taking edge so outputs are settled
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    SFR_ADDR <= a;
    SFR_WDATA <= d;
    SFR_WR <= wr;
    SFR_RD <= ~wr;
    @(posedge SYS_CLK);
    SFR_WR <= 1'b0;
    SFR_RD <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic sel);
    acc(1'b0, a, 8'h00);
    chk(SFR_RSEL === sel && SFR_RDATA === e, "read back");
  endtask
  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge SYS_CLK);
    RST <= 1'b0;
    rd(8'h8f, 8'h00, 1'b1);
    rd(8'h9f, 8'h00, 1'b1);
    chk(CPU_DOUBLE_SPEED === 1'b0 && MACHINE_PERIODS === 4'hc, "reset mode");
    foreach (rows[r]) begin
      acc(1'b1, 8'h8f, rows[r][23:16]);
      acc(1'b1, 8'h9f, rows[r][15:8]);
      // mode is applied within two cycles; three leaves margin
      repeat (3) @(posedge SYS_CLK);
      #1;
      for (k0 = 0; k0 < 8; k0++) begin
        per[4*k0 +: 4] = rows[r][k0] ? mccs_pkg::PERIODS_DOUBLE : mccs_pkg::PERIODS_STANDARD;
      end
      chk(PERIPH_DOUBLE_EN === rows[r][7:0], "peripheral double enable");
      chk(PERIPH_PERIODS === per, "peripheral periods");
      chk(MACHINE_PERIODS === (rows[r][16] ? 4'h6 : 4'hc), "machine periods");
      chk(CPU_DOUBLE_SPEED === rows[r][16], "applied mode");
      ce2[0] = CORE_CLK_EN;
      @(posedge SYS_CLK);
      #1;
      ce2[1] = CORE_CLK_EN;
      chk(rows[r][16] ? ce2 === 2'b11 : (ce2 === 2'b01 || ce2 === 2'b10), "core tick");
      rd(8'h8f, rows[r][23:16], 1'b1);
      rd(8'h9f, rows[r][15:8] & 8'h01, 1'b1);
    end
    // unmapped address must neither answer nor disturb the registers or the read data
    acc(1'b1, 8'h8e, 8'hff);
    rd(8'h8e, 8'h00, 1'b0);
    rd(8'h8f, 8'hab, 1'b1);
    // second reset in mid-run while double speed is active
    acc(1'b1, 8'h8f, 8'hff);
    repeat (3) @(posedge SYS_CLK);
    #1;
    chk(CPU_DOUBLE_SPEED === 1'b1, "double speed before reset");
    @(posedge SYS_CLK);
    RST <= 1'b1;
    @(posedge SYS_CLK);
    RST <= 1'b0;
    #1;
    chk(CPU_DOUBLE_SPEED === 1'b0 && PERIPH_DOUBLE_EN === 8'h00, "mode after reset");
    rd(8'h8f, 8'h00, 1'b1);
    // frozen block takes no access, gives no tick and keeps its read data
    @(posedge SYS_CLK);
    CE <= 1'b0;
    acc(1'b1, 8'h8f, 8'h01);
    chk(CORE_CLK_EN === 1'b0, "core tick while frozen");
    rd(8'h8f, 8'h00, 1'b0);
    @(posedge SYS_CLK);
    CE <= 1'b1;
    rd(8'h8f, 8'h00, 1'b1);
    close_out();
  end
  initial begin
    #40000;
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
